// ### design/sbw_pkg.sv
// sbw_pkg: shared constants and carrier types for the byte-lane write mask SRAM.
// assumes: every user refers to names as sbw_pkg::name, nothing is imported.
package sbw_pkg;

  // ----------------------------------------------------------------
  // widths and organisation
  // ----------------------------------------------------------------
  localparam int LANE_W       = 9;   // bits per byte lane
  localparam int MAX_LANES    = 4;   // widest organisation has four lanes
  localparam int MAX_DATA_W   = 36;  // LANE_W * MAX_LANES
  localparam int MAX_ADDR_W   = 20;  // widest pin address carried
  localparam int DEF_DATA_W   = 18;  // default organisation
  localparam int DEF_ADDR_W   = 8;   // default pair address width, giving 256 burst pairs
  localparam int SYNC_STAGES  = 2;   // flip-flops on every pin before use

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_OE_N   = 1'b1; // read data pins released
  localparam logic RST_PIN_HI = 1'b1; // active-low pins idle high

  // burst word positions
  localparam logic WORD_FIRST  = 1'b0;
  localparam logic WORD_SECOND = 1'b1;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WR_IDLE   = 2'b01,
    WR_SECOND = 2'b10
  } sbw_wr_state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // all pins sampled from the bus, carried as one bundle through the synchroniser
  typedef struct packed {
    logic                  k;
    logic                  k_n;
    logic                  c;
    logic                  c_n;
    logic                  single_clk;
    logic                  rd_sel_n;
    logic                  wr_sel_n;
    logic [MAX_LANES-1:0]  lane_sel_n;
    logic [MAX_DATA_W-1:0] d;
    logic [MAX_ADDR_W-1:0] addr;
  } sbw_pins_t;

  // one write word with its lane selects and burst address
  typedef struct packed {
    logic [MAX_ADDR_W-1:0] addr;
    logic [MAX_DATA_W-1:0] data;
    logic [MAX_LANES-1:0]  lane_sel_n;
  } sbw_wr_t;

endpackage : sbw_pkg

// ### design/sbw_lane_merge.sv
// sbw_lane_merge: merges a new write word into the stored word lane by lane.
// assumes: purely combinational; caller supplies the stored word and selects.
`timescale 1ns/1ps
`default_nettype none

module sbw_lane_merge #(
  parameter int LANES  = 2,
  parameter int LANE_W = sbw_pkg::LANE_W
) (
  // words
  input  wire logic [LANES*LANE_W-1:0] old_word,
  input  wire logic [LANES*LANE_W-1:0] new_word,
  // active-low lane selects
  input  wire logic [LANES-1:0]        sel_n,
  // result
  output logic      [LANES*LANE_W-1:0] merged
);

  // ----------------------------------------------------------------
  // per-lane select
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi = gi + 1)
    begin : g_lane
      // one select per lane
      // low select takes the new lane, high keeps the stored lane
      assign merged[gi*LANE_W +: LANE_W] = sel_n[gi] ? old_word[gi*LANE_W +: LANE_W]
                                                     : new_word[gi*LANE_W +: LANE_W];
    end
  endgenerate

endmodule // sbw_lane_merge

`default_nettype wire

// ### design/sbw_sram.sv
// sbw_sram: burst SRAM core with separate read and write ports and
// byte-lane write masking on both words of every write burst.
// assumes: one core clock much faster than the pin clocks; all pins are
// asynchronous to it and are brought in through two flip-flops.
//
// Function
// - x18, both selects low writes all bits
// - x18, select 0 only writes lower lane
// - x18, select 1 only writes upper lane
// - all selects high leave location unchanged
// - selects judged separately for each word
// - x9, single select gates the word
// - x36, all selects low write all
// - x36, select 0 writes bits 8:0
// - x36, select 1 writes bits 17:9
// - x36, select 2 writes bits 26:18
// - x36, select 3 writes bits 35:27
// - power up deselected, read pins released
// - first word at A, second at A+1
// - write on K and K# rises, read on output clocks
// - selects sampled alongside each data word
`timescale 1ns/1ps
`default_nettype none

module sbw_sram #(
  parameter int DATA_W = sbw_pkg::DEF_DATA_W,
  parameter int ADDR_W = sbw_pkg::DEF_ADDR_W
) (
  // core clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  // input and output timing references
  input  wire logic                           k,
  input  wire logic                           k_n,
  input  wire logic                           c,
  input  wire logic                           c_n,
  input  wire logic                           single_clk_mode,
  // port selects and address
  input  wire logic                           read_port_select_n,
  input  wire logic                           write_port_select_n,
  input  wire logic [ADDR_W-1:0]              addr,
  // write data with lane selects
  input  wire logic [DATA_W-1:0]              d,
  input  wire logic [DATA_W/sbw_pkg::LANE_W-1:0] byte_lane_write_select_n,
  // read data, output enable low while driving
  output logic      [DATA_W-1:0]              q,
  output logic                                q_oe_n
);

  localparam int LANES = DATA_W / sbw_pkg::LANE_W;
  localparam int DEPTH = 2 ** (ADDR_W + 1);

  // ----------------------------------------------------------------
  // burst address decode
  // ----------------------------------------------------------------
  // pair address plus word position gives the array index
  function automatic logic [ADDR_W:0] burst_index(input logic [ADDR_W-1:0] a,
                                                  input logic              word);
    burst_index = {a, word};
  endfunction

  // ----------------------------------------------------------------
  // pin bundle and synchroniser
  // ----------------------------------------------------------------
  sbw_pkg::sbw_pins_t pins_raw;
  sbw_pkg::sbw_pins_t sync1_q;
  sbw_pkg::sbw_pins_t sync2_q;
  sbw_pkg::sbw_pins_t prev_q;

  // references and active-low pins leave reset at a high level, so that no
  // false rise is detected on the first edges after release
  localparam sbw_pkg::sbw_pins_t PINS_RST = '{k: sbw_pkg::RST_PIN_HI, k_n: sbw_pkg::RST_PIN_HI,
    c: sbw_pkg::RST_PIN_HI, c_n: sbw_pkg::RST_PIN_HI, rd_sel_n: sbw_pkg::RST_PIN_HI,
    wr_sel_n: sbw_pkg::RST_PIN_HI, lane_sel_n: '1, default: '0};

  // narrow ports sit in the low bits of the wide bundle
  always_comb
  begin
    pins_raw                  = '0;
    pins_raw.k                = k;
    pins_raw.k_n              = k_n;
    pins_raw.c                = c;
    pins_raw.c_n              = c_n;
    pins_raw.single_clk       = single_clk_mode;
    pins_raw.rd_sel_n              = read_port_select_n;
    pins_raw.wr_sel_n              = write_port_select_n;
    pins_raw.lane_sel_n[LANES-1:0] = byte_lane_write_select_n;
    pins_raw.d[DATA_W-1:0]    = d;
    pins_raw.addr[ADDR_W-1:0] = addr;
  end

  // data and strobes share one delay so each word stays aligned to its edge;
  // stage one is read only by stage two
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync1_q <= PINS_RST;
      sync2_q <= PINS_RST;
      prev_q  <= PINS_RST;
    end
    else
    begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // ----------------------------------------------------------------
  // edge detection on the synchronised references
  // ----------------------------------------------------------------
  wire logic out_clk;
  wire logic out_clk_n;
  wire logic prev_out_clk;
  wire logic prev_out_clk_n;
  wire logic k_rise;
  wire logic kn_rise;
  wire logic oc_rise;
  wire logic ocn_rise;

  // single clock mode moves reads onto the input references
  assign out_clk        = sync2_q.single_clk ? sync2_q.k   : sync2_q.c;
  assign out_clk_n      = sync2_q.single_clk ? sync2_q.k_n : sync2_q.c_n;
  assign prev_out_clk   = prev_q.single_clk  ? prev_q.k    : prev_q.c;
  assign prev_out_clk_n = prev_q.single_clk  ? prev_q.k_n  : prev_q.c_n;
  // only rising edges of the references act
  assign k_rise         = sync2_q.k & ~prev_q.k;
  assign kn_rise        = sync2_q.k_n & ~prev_q.k_n;
  assign oc_rise        = out_clk & ~prev_out_clk;
  assign ocn_rise       = out_clk_n & ~prev_out_clk_n;

  // ----------------------------------------------------------------
  // storage array
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [DEPTH];

  // ----------------------------------------------------------------
  // write port
  // ----------------------------------------------------------------
  sbw_pkg::sbw_wr_state_t wr_state_q;
  sbw_pkg::sbw_wr_state_t wr_state_d;
  sbw_pkg::sbw_wr_t       wr_hold_q;
  sbw_pkg::sbw_wr_t       wr_word;
  logic                   wr_en;
  logic                   wr_pos;
  wire  logic             wr_start;
  wire  logic [ADDR_W:0]  wr_index;
  wire  logic [DATA_W-1:0] wr_merged;

  // a write opens on a K rise with the write port select low
  assign wr_start = k_rise & ~sync2_q.wr_sel_n;

  // next write state; the second word takes priority over a fresh start,
  // so a K# rise seen in the same core cycle is never dropped
  always_comb
  begin
    wr_state_d = wr_state_q;
    wr_en      = 1'b0;
    wr_pos     = sbw_pkg::WORD_FIRST;
    wr_word    = '0;
    case (wr_state_q)
      sbw_pkg::WR_IDLE:
      begin
        if (wr_start)
        begin
          // the first word carries the selects seen with it
          wr_word.addr       = sync2_q.addr;
          wr_word.data       = sync2_q.d;
          wr_word.lane_sel_n = sync2_q.lane_sel_n;
          wr_en         = 1'b1;
          wr_state_d    = sbw_pkg::WR_SECOND;
        end
      end
      sbw_pkg::WR_SECOND:
      begin
        if (kn_rise)
        begin
          // second word uses freshly sampled selects, not the first ones
          wr_word.addr       = wr_hold_q.addr;
          wr_word.data       = sync2_q.d;
          wr_word.lane_sel_n = sync2_q.lane_sel_n;
          wr_pos        = sbw_pkg::WORD_SECOND;
          wr_en         = 1'b1;
          wr_state_d    = sbw_pkg::WR_IDLE;
        end
      end
      default:
      begin
        wr_state_d = sbw_pkg::WR_IDLE;
      end
    endcase
  end

  // burst word position picks A+0 or A+1
  assign wr_index = burst_index(wr_word.addr[ADDR_W-1:0], wr_pos);

  // lane-wise merge
  // each lane takes new data only where its select is low
  sbw_lane_merge #(
    .LANES  (LANES),
    .LANE_W (sbw_pkg::LANE_W)
  ) u_merge (
    .old_word (mem_q[wr_index]),
    .new_word (wr_word.data[DATA_W-1:0]),
    .sel_n    (wr_word.lane_sel_n[LANES-1:0]),
    .merged   (wr_merged)
  );

  // write state and held burst address
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_state_q <= sbw_pkg::WR_IDLE;
      wr_hold_q  <= '0;
    end
    else
    begin
      wr_state_q <= wr_state_d;
      if (wr_start && wr_state_q == sbw_pkg::WR_IDLE)
      begin
        // address latched when the write opens
        wr_hold_q <= wr_word;
      end
    end
  end

  // array write; all-high selects rewrite the stored word unchanged
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      // merged word equals stored word when no lane is selected
      mem_q[wr_index] <= wr_merged;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic              rd_pend_q;
  logic [ADDR_W-1:0] rd_pend_addr_q;
  logic              rd_act_q;
  logic [ADDR_W-1:0] rd_act_addr_q;
  logic              rd_w1_q;
  logic [ADDR_W-1:0] rd_w1_addr_q;
  logic [DATA_W-1:0] q_q;
  logic              q_oe_n_q;
  wire  logic [ADDR_W:0] rd_index0;
  wire  logic [ADDR_W:0] rd_index1;

  // read burst order A+0 then A+1
  assign rd_index0 = burst_index(rd_act_addr_q, sbw_pkg::WORD_FIRST);
  assign rd_index1 = burst_index(rd_w1_addr_q, sbw_pkg::WORD_SECOND);

  // request pipeline: taken on one K rise, launched on the next
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rd_pend_q      <= 1'b0;
      rd_pend_addr_q <= '0;
      rd_act_q       <= 1'b0;
      rd_act_addr_q  <= '0;
    end
    else if (k_rise)
    begin
      rd_pend_q      <= ~sync2_q.rd_sel_n;
      rd_pend_addr_q <= sync2_q.addr[ADDR_W-1:0];
      rd_act_q       <= rd_pend_q;
      rd_act_addr_q  <= rd_pend_addr_q;
    end
    else if (ocn_rise)
    begin
      rd_act_q <= 1'b0;             // first word consumed
    end
  end

  // output words; pins released on the output edge after the last word
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      // deselected at power up with read pins released
      rd_w1_q      <= 1'b0;
      rd_w1_addr_q <= '0;
      q_q          <= '0;
      q_oe_n_q     <= sbw_pkg::RST_OE_N;
    end
    else if (ocn_rise && rd_act_q)
    begin
      // first word on the negative output reference
      q_q          <= mem_q[rd_index0];
      q_oe_n_q     <= 1'b0;
      rd_w1_q      <= 1'b1;
      rd_w1_addr_q <= rd_act_addr_q;
    end
    else if (oc_rise && rd_w1_q)
    begin
      // second word on the positive output reference
      q_q     <= mem_q[rd_index1];
      rd_w1_q <= 1'b0;
    end
    else if ((oc_rise || ocn_rise) && !rd_w1_q)
    begin
      q_oe_n_q <= sbw_pkg::RST_OE_N; // tristate after the burst
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from flip-flops
  // ----------------------------------------------------------------
  assign q      = q_q;
  assign q_oe_n = q_oe_n_q;

endmodule // sbw_sram

`default_nettype wire

// ### test/sbw_sram_chk.sv
// sbw_sram_chk: timing checks on the read pins of sbw_sram.
// assumes: bound to sbw_sram, pin clocks far slower than core_clk.
`timescale 1ns/1ps
`default_nettype none

module sbw_sram_chk #(parameter int DATA_W = sbw_pkg::DEF_DATA_W) (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst,
  // pin clocks and read select
  input wire logic              k,
  input wire logic              c,
  input wire logic              c_n,
  input wire logic              single_clk_mode,
  input wire logic              read_port_select_n,
  // read pins
  input wire logic [DATA_W-1:0] q,
  input wire logic              q_oe_n
);
  // ------------------------------------------------------------
  // ages since an output reference rose and since a read was asked
  // ------------------------------------------------------------
  logic       c_q;
  logic       cn_q;
  logic [7:0] ref_q;
  logic [7:0] rd_q;
  wire        rise  = (c && !c_q) || (c_n && !cn_q);
  // saturate so that a long idle never wraps back into range
  wire [7:0]  ref_d = rise ? 8'h00 : ref_q + {7'h00, ref_q != 8'hFF};
  wire [7:0]  rd_d  = !read_port_select_n ? 8'h00 : rd_q + {7'h00, rd_q != 8'hFF};

  // previous pin levels and both ages
  always_ff @(posedge core_clk)
  begin
    c_q   <= c;
    cn_q  <= c_n;
    ref_q <= rst ? 8'hFF : ref_d;
    rd_q  <= rst ? 8'hFF : rd_d;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_rst_rel; $fell(rst) |-> q_oe_n && (q == '0); endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("read pins driven at reset exit");
  property p_idle_rel; rd_q > 8'h64 |-> q_oe_n; endproperty
  a_idle_rel: assert property (p_idle_rel) else $error("read pins driven while idle");
  property p_idle_q; rd_q > 8'h64 |-> $stable(q); endproperty
  a_idle_q: assert property (p_idle_q) else $error("q moved with no read");
  property p_q_ref; !single_clk_mode && $changed(q) |-> ref_q <= 8'h06; endproperty
  a_q_ref: assert property (p_q_ref) else $error("q moved away from a reference rise");
  property p_oe_ref; !single_clk_mode && $changed(q_oe_n) |-> ref_q <= 8'h06; endproperty
  a_oe_ref: assert property (p_oe_ref) else $error("enable moved off a reference");
  property p_rd_go; $rose(k) && !read_port_select_n |-> ##[8:100] !q_oe_n; endproperty
  a_rd_go: assert property (p_rd_go) else $error("accepted read never drove q");
  property p_burst; $fell(q_oe_n) |=> !q_oe_n [*8]; endproperty
  a_burst: assert property (p_burst) else $error("burst released after one word");
  property p_q_hold; $changed(q) |=> $stable(q) [*3]; endproperty
  a_q_hold: assert property (p_q_hold) else $error("q word did not hold");
endmodule // sbw_sram_chk

`default_nettype wire

// ### test/sbw_ctl_model.sv
// sbw_ctl_model: controller driving sbw_sram pins in whole pin cycles.
// assumes: core_clk paces the pins; each level lasts eight core cycles.
`timescale 1ns/1ps
`default_nettype none

module sbw_ctl_model #(
  parameter int DATA_W = sbw_pkg::DEF_DATA_W,
  parameter int ADDR_W = sbw_pkg::DEF_ADDR_W
) (
  // pacing clock
  input  wire logic                         core_clk,
  // output references parked high while set
  input  wire logic                         c_stop,
  // pin clocks
  output logic                              k,
  output logic                              k_n,
  output logic                              c,
  output logic                              c_n,
  // selects, address and write data
  output logic                              rd_sel_n,
  output logic                              wr_sel_n,
  output logic [ADDR_W-1:0]                 addr,
  output logic [DATA_W-1:0]                 d,
  output logic [DATA_W/sbw_pkg::LANE_W-1:0] lane_sel_n,
  // read pins
  input  wire logic [DATA_W-1:0]            q,
  input  wire logic                         q_oe_n
);
  // ------------------------------------------------------------
  // pin cycle; clocks stand still between calls
  // ------------------------------------------------------------
  // stopped output references park high; k keeps a low park and k_n a high one,
  // since k parked high would hide the next k rise
  task automatic refs(input logic v);
    k = v;
    k_n = !v;
    c = c_stop | v;
    c_n = c_stop | !v;
  endtask

  task automatic pace;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // read pins are looked at four core cycles after each rise
  task automatic cyc(input logic wr_n, input logic rd_n, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d0, input logic [DATA_W/sbw_pkg::LANE_W-1:0] s0,
    input logic [DATA_W-1:0] d1, input logic [DATA_W/sbw_pkg::LANE_W-1:0] s1,
    output logic [DATA_W-1:0] qk, output logic oek,
    output logic [DATA_W-1:0] qn, output logic oen);
    // request and first word set up before k rise
    wr_sel_n = wr_n;
    rd_sel_n = rd_n;
    addr = a;
    d = d0;
    lane_sel_n = s0;
    pace;
    refs(1'b1);
    pace;
    qk = q;
    oek = q_oe_n;
    // second word with its own selects; port selects released
    wr_sel_n = 1'b1;
    rd_sel_n = 1'b1;
    addr = ~a;
    d = d1;
    lane_sel_n = s1;
    pace;
    refs(1'b0);
    pace;
    qn = q;
    oen = q_oe_n;
  endtask

  // idle pins: clocks parked, selects high
  initial
  begin
    refs(1'b0);
    wr_sel_n = 1'b1;
    rd_sel_n = 1'b1;
    addr = '0;
    d = '0;
    lane_sel_n = '1;
  end
endmodule // sbw_ctl_model

`default_nettype wire

// ### test/sbw_sram_tb.sv
// sbw_sram_tb: directed bench for lane masked writes and burst reads.
// assumes: sbw_ctl_model makes the pin clocks; core_clk runs at 10 MHz.
`timescale 1ns/1ps
`default_nettype none

module sbw_sram_tb;
  localparam int DW = 18;
  localparam int AW = 8;
  localparam int LN = DW / sbw_pkg::LANE_W;
  logic          core_clk;
  logic          rst;
  logic          single_clk = 1'b0;
  logic          c_stop = 1'b0;
  logic          k, k_n, c, c_n, rd_sel_n, wr_sel_n, q_oe_n, oek, oen;
  logic [AW-1:0] addr;
  logic [DW-1:0] d, q, qk, qn;
  logic [LN-1:0] lane_sel_n;
  logic [DW-1:0] e0 [4];
  logic [DW-1:0] e1 [4];
  int            num_errors;
  int            n_compared;

  sbw_sram #(.DATA_W(DW), .ADDR_W(AW)) u_dut (.core_clk(core_clk), .rst(rst), .k(k),
    .k_n(k_n), .c(c), .c_n(c_n), .single_clk_mode(single_clk), .read_port_select_n(rd_sel_n),
    .write_port_select_n(wr_sel_n), .addr(addr), .d(d),
    .byte_lane_write_select_n(lane_sel_n), .q(q), .q_oe_n(q_oe_n));
  sbw_ctl_model #(.DATA_W(DW), .ADDR_W(AW)) u_ctl (.core_clk(core_clk), .c_stop(c_stop),
    .k(k), .k_n(k_n),
    .c(c), .c_n(c_n), .rd_sel_n(rd_sel_n), .wr_sel_n(wr_sel_n), .addr(addr), .d(d),
    .lane_sel_n(lane_sel_n), .q(q), .q_oe_n(q_oe_n));

  // 100 ns core clock
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // reference lane merge: a low select takes the new lane
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
    input logic [LN-1:0] sel_n);
    merge = old;
    for (int i = 0; i < LN; i++)
      if (!sel_n[i])
        merge[i*sbw_pkg::LANE_W +: sbw_pkg::LANE_W] = nw[i*sbw_pkg::LANE_W +: sbw_pkg::LANE_W];
  endfunction

  // pin cycle with no write; data lines carry a moving pattern
  task automatic idle(input logic rd_n, input logic [AW-1:0] a);
    u_ctl.cyc(1'b1, rd_n, a, 18'h2_5A5A, 2'b01, 18'h1_A5A5, 2'b10, qk, oek, qn, oen);
  endtask

  // back-to-back reads of a then b, both bursts judged
  task automatic rd2(input logic [AW-1:0] a, input logic [AW-1:0] b, input logic [DW-1:0] ea0,
    input logic [DW-1:0] ea1, input logic [DW-1:0] eb0, input logic [DW-1:0] eb1);
    idle(1'b0, a);
    idle(1'b0, b);
    check(qn, ea0);
    check(DW'(oen), '0);
    idle(1'b1, ~b);
    check(qk, ea1);
    check(DW'(oek), '0);
    check(qn, eb0);
    idle(1'b1, b);
    check(qk, eb1);
    check(DW'(oen), DW'(1'b1));
  endtask

  task automatic t_reset;
    check(q, '0);
    check(DW'(q_oe_n), DW'(1'b1));
    idle(1'b1, 8'h00);
    check(DW'(oen), DW'(1'b1));
  endtask

  // every select pattern on word0, its inverse on word1, near the top address
  task automatic t_lanes;
    logic [AW-1:0] a;
    logic [LN-1:0] p;
    for (int i = 0; i < 4; i++)
    begin
      a = 8'hFC + AW'(i);
      p = LN'(i);
      u_ctl.cyc(1'b0, 1'b1, a, 18'h2_AAAA, 2'b00, 18'h1_5555, 2'b00, qk, oek, qn, oen);
      u_ctl.cyc(1'b0, 1'b1, a, 18'h1_2345, p, 18'h3_4567, ~p, qk, oek, qn, oen);
      e0[i] = merge(18'h2_AAAA, 18'h1_2345, p);
      e1[i] = merge(18'h1_5555, 18'h3_4567, ~p);
      rd2(a, a, e0[i], e1[i], e0[i], e1[i]);
    end
  endtask

  // two different pairs read on consecutive k rises
  task automatic t_b2b;
    rd2(8'hFC, 8'hFF, e0[0], e1[0], e0[3], e1[3]);
  endtask

  // single clock mode: output references stand high, reads must ride k and k_n
  task automatic t_single;
    single_clk = 1'b1;
    c_stop = 1'b1;
    rd2(8'hFD, 8'hFE, e0[1], e1[1], e0[2], e1[2]);
  endtask

  // main sequence
  initial
  begin
    num_errors = 0;
    n_compared = 0;
    rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    @(posedge core_clk);
    #1;
    t_reset;
    t_lanes;
    t_b2b;
    t_single;
    wrap_up;
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    wrap_up;
  end
endmodule // sbw_sram_tb

bind sbw_sram sbw_sram_chk #(.DATA_W(DATA_W)) u_chk (.core_clk(core_clk), .rst(rst), .k(k),
  .c(c), .c_n(c_n), .single_clk_mode(single_clk_mode),
  .read_port_select_n(read_port_select_n), .q(q), .q_oe_n(q_oe_n));

`default_nettype wire
